// File: hdl/dtrsm_top.v
// dual 16-bit timer/counter with reload, 8-bit reload and split modes
`timescale 1ns/100ps
`default_nettype none
`include "dtrsm_defines.vh"

module dtrsm_top #(
	parameter ADR_W = 10 // wishbone byte address width
) (
	input wire core_clk_i, // system clock, 10 MHz
	input wire reset_n_i, // async reset, active low
	input wire wb_cyc_i, // bus cycle
	input wire wb_stb_i, // strobe
	input wire wb_we_i, // write enable
	input wire [ADR_W-1:0] wb_adr_i, // byte address
	input wire [3:0] wb_sel_i, // byte lanes
	input wire [31:0] wb_dat_i, // write data
	output reg [31:0] wb_dat_o, // read data
	output reg wb_ack_o, // acknowledge
	input wire count_pin_first_i, // timer 0 count pin
	input wire count_pin_second_i, // timer 1 count pin
	input wire ext_irq_pin_first_i, // external irq 0 pin
	input wire ext_irq_pin_second_i, // external irq 1 pin
	input wire vec_ovf_first_i, // cpu vectored to timer 0 irq
	input wire vec_ovf_second_i, // cpu vectored to timer 1 irq
	input wire vec_edge_first_i, // cpu processed ext irq 0
	input wire vec_edge_second_i, // cpu processed ext irq 1
	output reg overflow_flag_first_o, // timer 0 irq request
	output reg overflow_flag_second_o, // timer 1 irq request
	output reg edge_flag_first_o, // ext irq 0 request
	output reg edge_flag_second_o, // ext irq 1 request
	output reg baud_tick_o // timer 1 overflow pulse
);

	// ============================================================
	// registers
	reg [7:0] timer_control_flags; // control/flag register
	reg [7:0] timer_mode_select; // mode register
	reg [7:0] count_low_first, count_high_first; // timer 0 bytes
	reg [7:0] count_low_second, count_high_second; // timer 1 bytes
	reg [7:0] reload_low_first, reload_high_first; // timer 0 reload
	reg [7:0] reload_low_second, reload_high_second; // timer 1 reload
	reg [`DTRSM_PSC_W-1:0] shared_prescale_setting; // divide by n+1
	reg [`DTRSM_PSC_W-1:0] psc_cnt; // prescaler counter
	reg pin_irq1_q, pin_irq2_q; // last samples of irq pins 0 and 1
	reg [7:0] next_cl0, next_ch0; // timer 0 next bytes
	reg [7:0] next_cl1, next_ch1; // timer 1 next bytes
	reg [7:0] next_timer_control_flags; // control/flags
	reg ovf0, ovf_h0, ovf1; // wraps: timer 0, split high, timer 1

	// ============================================================
	// decoded fields
	wire [7:0] widx = wb_adr_i[9:2]; // register index
	wire [7:0] wd = wb_dat_i[7:0]; // write data byte
	// writes land on the acknowledging edge only
	wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	wire [1:0] mode_first = timer_mode_select[`DTRSM_MODE_HI:`DTRSM_MODE_LO];
	wire [1:0] mode_second = timer_mode_select[`DTRSM_MODE1_HI:`DTRSM_MODE1_LO];
	wire split = (mode_first == `DTRSM_M_SPLIT); // timer 0 split
	wire tick; // shared prescaler tick
	wire en0, en1, en_h0; // timer 0 or split low, timer 1, split high
	wire run_bit_first = timer_control_flags[`DTRSM_RUN1]; // timer 0 run
	wire run_bit_second = timer_control_flags[`DTRSM_RUN2]; // timer 1 run
	// mode 3 on timer 1 acts as a cleared run bit
	wire run_second_eff = run_bit_second &
		(mode_second != `DTRSM_M_SPLIT);

	// ============================================================
	// shared prescaler
	assign tick = (psc_cnt == shared_prescale_setting);

	// free-running, one tick every setting+1 clocks
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			psc_cnt <= `DTRSM_RST_PSC;
		end else begin
			psc_cnt <= tick ? `DTRSM_RST_PSC : psc_cnt + 1'b1;
		end
	end

	// ============================================================
	// count enable sources
	// timer 0, also the split low byte
	dtrsm_cnt_src u_src0 (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .tick_i(tick),
		.count_pin_i(count_pin_first_i),
		.ext_irq_pin_i(ext_irq_pin_first_i),
		.csel_i(timer_mode_select[`DTRSM_CSEL]), .gate_i(timer_mode_select[`DTRSM_GATE]),
		.run_i(run_bit_first), .cnt_en_o(en0)
	);

	// timer 1 with its own settings
	dtrsm_cnt_src u_src1 (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .tick_i(tick),
		.count_pin_i(count_pin_second_i),
		.ext_irq_pin_i(ext_irq_pin_second_i),
		.csel_i(timer_mode_select[`DTRSM_CSEL1]), .gate_i(timer_mode_select[`DTRSM_GATE1]),
		.run_i(run_second_eff), .cnt_en_o(en1)
	);

	// split high byte: timer only, no gate, timer 1 run bit
	dtrsm_cnt_src u_srch (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .tick_i(tick),
		.count_pin_i(1'b0), .ext_irq_pin_i(1'b1),
		.csel_i(1'b0), .gate_i(1'b0),
		.run_i(run_bit_second & split), .cnt_en_o(en_h0)
	);

	// ============================================================
	// timer 0 counting
	// variable-width mode is not carried here: the count holds
	always @* begin
		next_cl0 = count_low_first;
		next_ch0 = count_high_first;
		ovf0 = 1'b0;
		ovf_h0 = 1'b0;
		case (mode_first)
			`DTRSM_M_16: begin
				if (en0) begin
					if ({count_high_first, count_low_first} == `DTRSM_ALL16) begin
						next_ch0 = reload_high_first;
						next_cl0 = reload_low_first;
						ovf0 = 1'b1;
					end else begin
						{next_ch0, next_cl0} =
							{count_high_first, count_low_first} + 16'h0001;
					end
				end
			end
			`DTRSM_M_8: begin
				if (en0) begin
					if (count_low_first == `DTRSM_ALL8) begin
						next_cl0 = count_high_first;
						ovf0 = 1'b1;
					end else begin
						next_cl0 = count_low_first + 8'h01;
					end
				end
			end
			`DTRSM_M_SPLIT: begin
				// two free 8-bit counters; reload pair unused
				if (en0) begin
					next_cl0 = count_low_first + 8'h01;
					ovf0 = (count_low_first == `DTRSM_ALL8);
				end
				if (en_h0) begin
					next_ch0 = count_high_first + 8'h01;
					ovf_h0 = (count_high_first == `DTRSM_ALL8);
				end
			end
			default: ;
		endcase
		// software write wins over a same-cycle reload
		if (wr && widx == `DTRSM_IDX_CL0) begin
			next_cl0 = wd;
		end
		if (wr && widx == `DTRSM_IDX_CH0) begin
			next_ch0 = wd;
		end
	end

	// ============================================================
	// timer 1 counting
	always @* begin
		next_cl1 = count_low_second;
		next_ch1 = count_high_second;
		ovf1 = 1'b0;
		case (mode_second)
			`DTRSM_M_16: begin
				if (en1) begin
					if ({count_high_second, count_low_second} == `DTRSM_ALL16) begin
						next_ch1 = reload_high_second;
						next_cl1 = reload_low_second;
						ovf1 = 1'b1;
					end else begin
						{next_ch1, next_cl1} =
							{count_high_second, count_low_second} + 16'h0001;
					end
				end
			end
			`DTRSM_M_8: begin
				if (en1) begin
					if (count_low_second == `DTRSM_ALL8) begin
						next_cl1 = count_high_second;
						ovf1 = 1'b1;
					end else begin
						next_cl1 = count_low_second + 8'h01;
					end
				end
			end
			default: begin
				// mode 3 holds the count; mode 0 not carried
			end
		endcase
		if (wr && widx == `DTRSM_IDX_CL1) begin
			next_cl1 = wd;
		end
		if (wr && widx == `DTRSM_IDX_CH1) begin
			next_ch1 = wd;
		end
	end

	// ============================================================
	// control/flag register
	// hardware set beats software or vectoring clear
	always @* begin
		next_timer_control_flags = timer_control_flags;
		if (wr && widx == `DTRSM_IDX_CTRL) begin
			next_timer_control_flags = wd;
		end
		if (vec_ovf_first_i) begin
			next_timer_control_flags[`DTRSM_OVF1] = 1'b0;
		end
		if (vec_ovf_second_i) begin
			next_timer_control_flags[`DTRSM_OVF2] = 1'b0;
		end
		if (ovf0) begin
			next_timer_control_flags[`DTRSM_OVF1] = 1'b1;
		end
		// timer 1 loses its flag to the split high byte
		if (ovf_h0 || (ovf1 && !split)) begin
			next_timer_control_flags[`DTRSM_OVF2] = 1'b1;
		end
		// edge mode: latch falling edge, clear when processed
		if (timer_control_flags[`DTRSM_TYP1]) begin
			if (vec_edge_first_i) begin
				next_timer_control_flags[`DTRSM_EDG1] = 1'b0;
			end
			if (pin_irq1_q && !ext_irq_pin_first_i) begin
				next_timer_control_flags[`DTRSM_EDG1] = 1'b1;
			end
		end else begin
			// level mode: flag follows a low pin
			next_timer_control_flags[`DTRSM_EDG1] = ~ext_irq_pin_first_i;
		end
		if (timer_control_flags[`DTRSM_TYP2]) begin
			if (vec_edge_second_i) begin
				next_timer_control_flags[`DTRSM_EDG2] = 1'b0;
			end
			if (pin_irq2_q && !ext_irq_pin_second_i) begin
				next_timer_control_flags[`DTRSM_EDG2] = 1'b1;
			end
		end else begin
			next_timer_control_flags[`DTRSM_EDG2] = ~ext_irq_pin_second_i;
		end
	end

	// ============================================================
	// state registers
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			timer_control_flags <= `DTRSM_RST8;
			timer_mode_select <= `DTRSM_RST8;
			count_low_first <= `DTRSM_RST8;
			count_high_first <= `DTRSM_RST8;
			count_low_second <= `DTRSM_RST8;
			count_high_second <= `DTRSM_RST8;
			reload_low_first <= `DTRSM_RST8;
			reload_high_first <= `DTRSM_RST8;
			reload_low_second <= `DTRSM_RST8;
			reload_high_second <= `DTRSM_RST8;
			shared_prescale_setting <= `DTRSM_RST_PSC;
			pin_irq1_q <= 1'b1;
			pin_irq2_q <= 1'b1;
		end else begin
			timer_control_flags <= next_timer_control_flags;
			count_low_first <= next_cl0;
			count_high_first <= next_ch0;
			count_low_second <= next_cl1;
			count_high_second <= next_ch1;
			pin_irq1_q <= ext_irq_pin_first_i;
			pin_irq2_q <= ext_irq_pin_second_i;
			if (wr) begin
				// reload pair is plain storage in every mode
				case (widx)
					`DTRSM_IDX_MODE: timer_mode_select <= wd;
					`DTRSM_IDX_RL0: reload_low_first <= wd;
					`DTRSM_IDX_RH0: reload_high_first <= wd;
					`DTRSM_IDX_RL1: reload_low_second <= wd;
					`DTRSM_IDX_RH1: reload_high_second <= wd;
					`DTRSM_IDX_PSC: shared_prescale_setting <= wd[`DTRSM_PSC_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// ============================================================
	// outputs
	// flags mirror the register one cycle later; baud tick
	// keeps running even while split mode owns the flag
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			overflow_flag_first_o <= 1'b0;
			overflow_flag_second_o <= 1'b0;
			edge_flag_first_o <= 1'b0;
			edge_flag_second_o <= 1'b0;
			baud_tick_o <= 1'b0;
		end else begin
			overflow_flag_first_o <= timer_control_flags[`DTRSM_OVF1];
			overflow_flag_second_o <= timer_control_flags[`DTRSM_OVF2];
			edge_flag_first_o <= timer_control_flags[`DTRSM_EDG1];
			edge_flag_second_o <= timer_control_flags[`DTRSM_EDG2];
			baud_tick_o <= ovf1;
		end
	end

	// ============================================================
	// wishbone slave: ack one cycle after the request,
	// dropped the cycle after; unmapped reads return zero
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `DTRSM_RD_ZERO;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				case (widx)
					`DTRSM_IDX_CTRL: wb_dat_o <= {24'h000000, timer_control_flags};
					`DTRSM_IDX_MODE: wb_dat_o <= {24'h000000, timer_mode_select};
					`DTRSM_IDX_CL0: wb_dat_o <= {24'h000000, count_low_first};
					`DTRSM_IDX_CH0: wb_dat_o <= {24'h000000, count_high_first};
					`DTRSM_IDX_CL1: wb_dat_o <= {24'h000000, count_low_second};
					`DTRSM_IDX_CH1: wb_dat_o <= {24'h000000, count_high_second};
					`DTRSM_IDX_RL0: wb_dat_o <= {24'h000000, reload_low_first};
					`DTRSM_IDX_RH0: wb_dat_o <= {24'h000000, reload_high_first};
					`DTRSM_IDX_RL1: wb_dat_o <= {24'h000000, reload_low_second};
					`DTRSM_IDX_RH1: wb_dat_o <= {24'h000000, reload_high_second};
					`DTRSM_IDX_PSC: wb_dat_o <= {28'h0000000, shared_prescale_setting};
					default: wb_dat_o <= `DTRSM_RD_ZERO;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// File: pkg/dtrsm_defines.vh
// register map, field positions and encodings of the dual timer
`ifndef DTRSM_DEFINES_VH
`define DTRSM_DEFINES_VH

// ============================================================
// register indices (byte address is four times the index)
`define DTRSM_IDX_CTRL 8'h88
`define DTRSM_IDX_MODE 8'h89
`define DTRSM_IDX_CL0 8'h8a
`define DTRSM_IDX_CL1 8'h8b
`define DTRSM_IDX_CH0 8'h8c
`define DTRSM_IDX_CH1 8'h8d
`define DTRSM_IDX_RL0 8'h92
`define DTRSM_IDX_RL1 8'h93
`define DTRSM_IDX_RH0 8'h94
`define DTRSM_IDX_RH1 8'h95
`define DTRSM_IDX_PSC 8'h96

// ============================================================
// control/flag register bits
`define DTRSM_OVF2 7
`define DTRSM_RUN2 6
`define DTRSM_OVF1 5
`define DTRSM_RUN1 4
`define DTRSM_EDG2 3
`define DTRSM_TYP2 2
`define DTRSM_EDG1 1
`define DTRSM_TYP1 0

// ============================================================
// mode register fields, per-timer nibble
`define DTRSM_GATE 3
`define DTRSM_CSEL 2
`define DTRSM_MODE_HI 1
`define DTRSM_MODE_LO 0
// the same fields in timer 1's upper nibble
`define DTRSM_MODE1_HI 5
`define DTRSM_MODE1_LO 4
`define DTRSM_CSEL1 6
`define DTRSM_GATE1 7

// ============================================================
// mode encodings
`define DTRSM_M_VAR 2'h0
`define DTRSM_M_16 2'h1
`define DTRSM_M_8 2'h2
`define DTRSM_M_SPLIT 2'h3

// ============================================================
// reset values and constants
`define DTRSM_RST8 8'h00
`define DTRSM_ALL8 8'hff
`define DTRSM_ALL16 16'hffff
`define DTRSM_PSC_W 4
`define DTRSM_RST_PSC 4'h0
`define DTRSM_RD_ZERO 32'h00000000

`endif

// File: hdl/dtrsm_cnt_src.v
// count-enable source: prescaled clock or falling edge on a count pin
`timescale 1ns/100ps
`default_nettype none

module dtrsm_cnt_src (
	input wire core_clk_i, // system clock
	input wire reset_n_i, // async reset, active low
	input wire tick_i, // one-cycle prescaler tick
	input wire count_pin_i, // external count input
	input wire ext_irq_pin_i, // gate pin
	input wire csel_i, // 1 selects the count pin
	input wire gate_i, // 1 gates with the pin
	input wire run_i, // run bit
	output reg cnt_en_o // one-cycle count enable
);

	// ============================================================
	// pin sampling
	reg pin_q; // previous sample of the count pin
	wire fall; // high then low seen
	wire enabled; // run and gate condition

	assign fall = pin_q & ~count_pin_i;
	assign enabled = run_i & (~gate_i | ext_irq_pin_i);

	// sample every clock; pins are synchronous already
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pin_q <= 1'b0;
			cnt_en_o <= 1'b0;
		end else begin
			pin_q <= count_pin_i;
			// registered so the count lands the cycle after detection
			if (csel_i) begin
				cnt_en_o <= fall & enabled;
			end else begin
				cnt_en_o <= tick_i & enabled;
			end
		end
	end

endmodule
`default_nettype wire

// File: tb/dtrsm_checker_assertions.sv
// checker: port-level properties of the dual timer block
`timescale 1ns/100ps
`default_nettype none
`include "dtrsm_defines.vh"
module dtrsm_checker #(
	parameter ADR_W = 10 // byte address width
) (
	input wire logic core_clk_i, // system clock
	input wire logic reset_n_i, // async reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [ADR_W-1:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // acknowledge
	input wire logic ext_irq_pin_first_i, // irq pin 0
	input wire logic overflow_flag_first_o, // timer 0 flag
	input wire logic overflow_flag_second_o, // timer 1 flag
	input wire logic edge_flag_first_o, // irq 0 flag
	input wire logic baud_tick_o // timer 1 overflow pulse
);
	// ====================
	// shadows of what software wrote
	logic [7:0] mode_sh; // last mode byte written
	logic type_sh; // last irq 0 type bit written
	wire wr_lands = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	wire [7:0] idx = wb_adr_i[9:2];
	// a write lands at the ack edge, so the shadows follow there
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_sh <= 8'h00;
			type_sh <= 1'b0;
		end else if (wr_lands && idx == `DTRSM_IDX_MODE) begin
			mode_sh <= wb_dat_i[7:0];
		end else if (wr_lands && idx == `DTRSM_IDX_CTRL) begin
			type_sh <= wb_dat_i[`DTRSM_TYP1];
		end
	end
	// ====================
	// properties
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_rd;
		wb_ack_o && !wb_we_i;
	endsequence
	a_ack_follows: assert property (s_req |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
		else $error("ack without a request");
	a_rd_upper: assert property (s_rd |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_unmapped_zero: assert property (s_rd and idx == 8'h90 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_mode_readback: assert property (s_rd and idx == `DTRSM_IDX_MODE |-> wb_dat_o[7:0] == mode_sh)
		else $error("mode byte read back wrong");
	a_reset_quiet: assert property ($rose(reset_n_i) |-> !overflow_flag_first_o && !overflow_flag_second_o && !baud_tick_o)
		else $error("flags not clear after reset");
	a_level_follow: assert property ($past(reset_n_i, 2) && !type_sh && !$past(type_sh) && !$past(type_sh, 2) |-> edge_flag_first_o == !$past(ext_irq_pin_first_i, 2))
		else $error("level flag not following pin");
endmodule
`default_nettype wire

// File: tb/dtrsm_pin_model.sv
// far-side model: count pins and irq/gate pins of the dual timer
`timescale 1ns/100ps
`default_nettype none
module dtrsm_pin_model (
	input wire logic core_clk_i, // system clock
	output logic count_pin_first_o, // timer 0 count pin
	output logic count_pin_second_o, // timer 1 count pin
	output logic ext_irq_pin_first_o, // irq/gate pin 0
	output logic ext_irq_pin_second_o // irq/gate pin 1
);
	// ====================
	// pins idle high, like a pulled-up input nobody drives
	initial begin
		count_pin_first_o = 1'b1;
		count_pin_second_o = 1'b1;
		ext_irq_pin_first_o = 1'b1;
		ext_irq_pin_second_o = 1'b1;
	end
	// falling edges on both count pins; each level stands hold clocks
	// so it is sampled at least once, and hold picks fast or slow
	task automatic count_pulses(input int n, input int hold);
		repeat (n) begin
			count_pin_first_o <= 1'b0;
			count_pin_second_o <= 1'b0;
			repeat (hold) @(posedge core_clk_i);
			count_pin_first_o <= 1'b1;
			count_pin_second_o <= 1'b1;
			repeat (hold) @(posedge core_clk_i);
		end
	endtask
	// gate and irq levels, changed just after a clock edge
	task automatic set_irq(input logic first, input logic second);
		ext_irq_pin_first_o <= first;
		ext_irq_pin_second_o <= second;
		@(posedge core_clk_i);
	endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the dual timer block
`timescale 1ns/100ps
`default_nettype none
`include "dtrsm_defines.vh"
module testbench;
	// ====================
	// design-facing signals and bench state
	logic clk, rst_n, cyc, stb, we, ack, baud;
	logic vo0, vo1, ve0, ve1, of0, of1, ef0, ef1;
	logic cp0, cp1, ip0, ip1;
	logic [9:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [7:0] r;
	logic [7:0] regs[7] = '{8'h88, 8'h89, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96};
	int mismatches = 0, check_count = 0, cyc_n = 0, last_t = -1;
	int tick_n = 0, n = 0;
	logic [7:0] rd_q[$]; // expected read bytes
	int per_q[$]; // expected tick spacings
	dtrsm_top #(.ADR_W(10)) dtrsm_top_inst (.core_clk_i(clk), .reset_n_i(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.count_pin_first_i(cp0), .count_pin_second_i(cp1),
		.ext_irq_pin_first_i(ip0), .ext_irq_pin_second_i(ip1),
		.vec_ovf_first_i(vo0), .vec_ovf_second_i(vo1),
		.vec_edge_first_i(ve0), .vec_edge_second_i(ve1),
		.overflow_flag_first_o(of0), .overflow_flag_second_o(of1),
		.edge_flag_first_o(ef0), .edge_flag_second_o(ef1), .baud_tick_o(baud));
	dtrsm_pin_model dtrsm_pin_model_inst (.core_clk_i(clk),
		.count_pin_first_o(cp0), .count_pin_second_o(cp1),
		.ext_irq_pin_first_o(ip0), .ext_irq_pin_second_o(ip1));
	// ====================
	// tasks
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// classic cycle: hold everything until ack is sampled high
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		rd_q.push_back(e);
		bus(1'b0, idx, 8'h00);
	endtask
	// two spacing notes; the first tick after a change only sets the mark
	task automatic period(input int p);
		last_t = -1;
		per_q.push_back(p);
		per_q.push_back(p);
		n = 0;
		while (per_q.size() > 0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check(per_q.size(), 0);
		per_q.delete();
	endtask
	// no tick may appear; a few clocks let any launched pulse pass first
	task automatic quiet(input int c);
		repeat (3) @(posedge clk);
		tick_n = 0;
		repeat (c) @(posedge clk);
		check(tick_n, 0);
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ====================
	// watcher: sampled mid-cycle so it never races the drivers
	always @(negedge clk) begin
		cyc_n++;
		if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
			check(rdat, {24'h000000, rd_q.pop_front()});
		if (baud === 1'b1) begin
			tick_n++;
			if (last_t >= 0 && per_q.size() > 0)
				check(cyc_n - last_t, per_q.pop_front());
			last_t = cyc_n;
		end
	end
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// watchdog: the sequence needs well under 8000 clocks
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
	// ====================
	// main sequence
	initial begin
		{cyc, stb, we, vo0, vo1, ve0, ve1} = 7'h00;
		adr = 10'h000;
		sel = 4'h1;
		wdat = 32'h0;
		rst_n = 1'b0;
		r = 8'($urandom(72333));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (regs[i]) rd(regs[i], 8'h00);
		rd(8'h90, 8'h00);
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			r = 8'($urandom);
			wr(8'(8'h92 + i), r);
			rd(8'(8'h92 + i), r);
		end
		r = 8'($urandom);
		wr(`DTRSM_IDX_MODE, r);
		rd(`DTRSM_IDX_MODE, r);
		$display("register storage done");
		wr(`DTRSM_IDX_PSC, 8'h01);
		wr(`DTRSM_IDX_RH1, 8'hff);
		wr(`DTRSM_IDX_RL1, 8'hf0);
		wr(`DTRSM_IDX_CH1, 8'hff);
		wr(`DTRSM_IDX_CL1, 8'hf0);
		wr(`DTRSM_IDX_MODE, 8'h10);
		wr(`DTRSM_IDX_CTRL, 8'h40);
		period(32);
		wr(`DTRSM_IDX_PSC, 8'h02);
		wr(`DTRSM_IDX_CH1, 8'hfb);
		wr(`DTRSM_IDX_CL1, 8'hfb);
		wr(`DTRSM_IDX_MODE, 8'h20);
		period(15);
		$display("timer periods done");
		wr(`DTRSM_IDX_CH1, 8'hfe);
		wr(`DTRSM_IDX_CL1, 8'hfe);
		wr(`DTRSM_IDX_MODE, 8'h60);
		fork
			dtrsm_pin_model_inst.count_pulses(8, 3);
			period(12);
		join
		dtrsm_pin_model_inst.set_irq(1'b1, 1'b0);
		wr(`DTRSM_IDX_CH1, 8'hfb);
		wr(`DTRSM_IDX_MODE, 8'ha0);
		quiet(60);
		check(ef1, 1'b1);
		dtrsm_pin_model_inst.set_irq(1'b1, 1'b1);
		period(15);
		check(ef1, 1'b0);
		$display("counter and gate done");
		wr(`DTRSM_IDX_MODE, 8'h30);
		quiet(60);
		vo1 <= 1'b1;
		@(posedge clk);
		vo1 <= 1'b0;
		repeat (4) @(posedge clk);
		check(of1, 1'b0);
		wr(`DTRSM_IDX_CH0, 8'h00);
		wr(`DTRSM_IDX_MODE, 8'h23);
		period(15);
		check(of1, 1'b0);
		wr(`DTRSM_IDX_MODE, 8'h33);
		quiet(60);
		n = 0;
		while (of1 !== 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		check(of1, 1'b1);
		$display("split mode done");
		wr(`DTRSM_IDX_MODE, 8'h32);
		wr(`DTRSM_IDX_CH0, 8'hf0);
		wr(`DTRSM_IDX_CL0, 8'hf0);
		wr(`DTRSM_IDX_CTRL, 8'h10);
		n = 0;
		while (of0 !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		check(of0, 1'b1);
		wr(`DTRSM_IDX_CTRL, 8'h20);
		vo0 <= 1'b1;
		@(posedge clk);
		vo0 <= 1'b0;
		repeat (4) @(posedge clk);
		check(of0, 1'b0);
		$display("overflow flag done");
		dtrsm_pin_model_inst.set_irq(1'b0, 1'b1);
		repeat (4) @(posedge clk);
		check(ef0, 1'b1);
		dtrsm_pin_model_inst.set_irq(1'b1, 1'b1);
		repeat (4) @(posedge clk);
		check(ef0, 1'b0);
		wr(`DTRSM_IDX_CTRL, 8'h05);
		dtrsm_pin_model_inst.set_irq(1'b0, 1'b0);
		repeat (4) @(posedge clk);
		check(ef0, 1'b1);
		check(ef1, 1'b1);
		dtrsm_pin_model_inst.set_irq(1'b1, 1'b1);
		repeat (4) @(posedge clk);
		check(ef0, 1'b1);
		check(ef1, 1'b1);
		ve0 <= 1'b1;
		ve1 <= 1'b1;
		@(posedge clk);
		ve0 <= 1'b0;
		ve1 <= 1'b0;
		repeat (4) @(posedge clk);
		check(ef0, 1'b0);
		check(ef1, 1'b0);
		$display("external flags done");
		give_verdict();
	end
endmodule
bind dtrsm_top dtrsm_checker #(.ADR_W(ADR_W)) dtrsm_checker_inst (.core_clk_i,
	.reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_irq_pin_first_i,
	.overflow_flag_first_o, .overflow_flag_second_o, .edge_flag_first_o,
	.baud_tick_o);
`default_nettype wire
